// file: cis_pkg.sv
// Constants and types for the core instruction subset executor.
// Assumes a single instruction clock; no bus, all controls are ports.
package cis_pkg;
    localparam int CIS_DATA_W = 8;
    localparam int CIS_PC_W = 15;
    localparam int CIS_FADDR_W = 7;
    localparam int CIS_WDT_W = 8;
    localparam int CIS_PRE_W = 8;
    localparam logic [7:0] CIS_ZERO = 8'h00;
    localparam logic [7:0] CIS_W_RST = 8'h00;
    localparam logic [14:0] CIS_PC_RST = 15'h0000;
    localparam logic [7:0] CIS_WDT_CLR = 8'h00;
    localparam logic [7:0] CIS_PRE_CLR = 8'h00;
    localparam logic CIS_DEST_W = 1'b0;
    localparam logic CIS_DEST_F = 1'b1;
    localparam logic [1:0] CIS_TWO_CYC = 2'h2;

    // Decoded operation of the current instruction
    typedef enum logic [3:0] {
        CIS_OP_NOP,
        CIS_OP_WDT_CLEAR,
        CIS_OP_CALL_W,
        CIS_OP_COMP_F,
        CIS_OP_CLEAR_F,
        CIS_OP_DEC_F,
        CIS_OP_CLEAR_W,
        CIS_OP_DEC_SKIP
    } cis_op_t;

    // Execution phase of the core
    typedef enum logic [1:0] {
        CIS_ST_EXEC,
        CIS_ST_FLUSH
    } cis_state_t;
endpackage

// file: cis_core.sv
// Execution of a subset of an 8-bit core's instructions: watchdog clear,
// call through working register, complement, clears, decrements.
// Assumes an outside fetch unit presents one decoded op per valid cycle,
// and an outside file register array returns o_faddr data same cycle.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// RQ1: Watchdog clear zeroes watchdog count and prescaler, sets timeout, powerdown.
// RQ2: Call via working register pushes program counter plus one onto stack.
// RQ3: Then loads PC low from working register, PC high from latch bits 6:0.
// RQ4: Call via working register takes two cycles, status flags untouched.
// RQ5: Destination bit zero writes working register, one writes file register.
// RQ6: Complement writes inverse of file register, updates zero flag.
// RQ7: Decrement writes file register minus one, updates zero flag.
// RQ8: Clear file writes zero to addressed file register, sets zero flag.
// RQ9: Clear working writes zero to working register, sets zero flag.
// RQ10: Decrement-skip sets no flags; zero result flushes next fetch as no-op.
// RQ11: Zero flag set when eight-bit result is zero, else cleared.
module cis_core
    import cis_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // Instruction presented by fetch
    input wire logic i_valid,
    input wire cis_op_t i_op,
    input wire logic [6:0] i_faddr,
    input wire logic i_dest,
    // File register array port
    input wire logic [7:0] i_fdata,
    output logic [6:0] o_faddr,
    output logic o_fwe,
    output logic [7:0] o_fwdata,
    // High program-counter latch value
    input wire logic [6:0] i_pc_high_latch,
    // Program counter and return stack push
    output logic [14:0] o_pc,
    output logic o_push,
    output logic [14:0] o_top_of_return_stack,
    // Fetch handshake: o_ready high when a new instruction can be accepted, o_discard high in the flush cycle
    output logic o_ready,
    output logic o_discard,
    // Core state
    output logic [7:0] o_working,
    output logic o_zero_flag,
    output logic o_timeout_flag,
    output logic o_powerdown_flag,
    output logic [7:0] o_watchdog_counter,
    output logic [7:0] o_watchdog_prescaler
);

    cis_state_t state;
    logic take;
    logic [7:0] dec_res;
    logic [7:0] cmp_res;
    logic [7:0] next_res;
    logic res_to_w;
    logic res_to_f;

    // Accept new work only in the execute phase
    assign take = i_valid && (state == CIS_ST_EXEC);
    assign o_ready = (state == CIS_ST_EXEC);
    assign o_discard = (state == CIS_ST_FLUSH);
    assign dec_res = i_fdata - 8'h01; // RQ7
    assign cmp_res = ~i_fdata; // RQ6

    // Result selection for file-sourced ops
    always_comb begin
        next_res = CIS_ZERO;
        case (i_op)
            CIS_OP_COMP_F: next_res = cmp_res; // RQ6
            CIS_OP_DEC_F: next_res = dec_res; // RQ7
            CIS_OP_DEC_SKIP: next_res = dec_res; // RQ10
            default: next_res = CIS_ZERO; // RQ8
        endcase
    end

    // Destination routing by the destination bit
    always_comb begin
        res_to_w = 1'b0;
        res_to_f = 1'b0;
        if (take) begin
            case (i_op)
                CIS_OP_COMP_F, CIS_OP_DEC_F, CIS_OP_DEC_SKIP: begin
                    res_to_w = (i_dest == CIS_DEST_W); // RQ5
                    res_to_f = (i_dest == CIS_DEST_F); // RQ5
                end
                CIS_OP_CLEAR_F: res_to_f = 1'b1; // RQ8
                default: begin
                    res_to_w = 1'b0;
                    res_to_f = 1'b0;
                end
            endcase
        end
    end

    // File write port is combinational so the write lands this cycle
    assign o_faddr = i_faddr;
    assign o_fwe = res_to_f;
    assign o_fwdata = next_res;

    // Phase machine: two-cycle ops spend one flush cycle
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= CIS_ST_EXEC;
        end else begin
            case (state)
                CIS_ST_EXEC: begin
                    if (take && i_op == CIS_OP_CALL_W) begin
                        state <= CIS_ST_FLUSH; // RQ4
                    end else if (take && i_op == CIS_OP_DEC_SKIP
                                 && dec_res == CIS_ZERO) begin
                        state <= CIS_ST_FLUSH; // RQ10
                    end
                end
                default: state <= CIS_ST_EXEC;
            endcase
        end
    end

    // Working register
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_working <= CIS_W_RST;
        end else if (take && i_op == CIS_OP_CLEAR_W) begin
            o_working <= CIS_ZERO; // RQ9
        end else if (res_to_w) begin
            o_working <= next_res; // RQ5
        end
    end

    // Zero flag; decrement-skip and call leave it alone
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_zero_flag <= 1'b0;
        end else if (take) begin
            case (i_op)
                CIS_OP_COMP_F, CIS_OP_DEC_F:
                    o_zero_flag <= (next_res == CIS_ZERO); // RQ11
                CIS_OP_CLEAR_F, CIS_OP_CLEAR_W:
                    o_zero_flag <= 1'b1; // RQ8 RQ9
                default: o_zero_flag <= o_zero_flag;
            endcase
        end
    end

    // Watchdog clear; power-on leaves both status flags set
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_watchdog_counter <= CIS_WDT_CLR;
            o_watchdog_prescaler <= CIS_PRE_CLR;
            o_timeout_flag <= 1'b1;
            o_powerdown_flag <= 1'b1;
        end else if (take && i_op == CIS_OP_WDT_CLEAR) begin
            o_watchdog_counter <= CIS_WDT_CLR; // RQ1
            o_watchdog_prescaler <= CIS_PRE_CLR; // RQ1
            o_timeout_flag <= 1'b1; // RQ1
            o_powerdown_flag <= 1'b1; // RQ1
        end
    end

    // Program counter and return-address push
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pc <= CIS_PC_RST;
            o_push <= 1'b0;
            o_top_of_return_stack <= CIS_PC_RST;
        end else begin
            o_push <= 1'b0;
            if (take && i_op == CIS_OP_CALL_W) begin
                o_push <= 1'b1; // RQ2
                o_top_of_return_stack <= o_pc + 15'h0001; // RQ2
                o_pc <= {i_pc_high_latch, o_working}; // RQ3
            end else if (take || state == CIS_ST_FLUSH) begin
                o_pc <= o_pc + 15'h0001;
            end
        end
    end

    // Checks and coverage
    a_wdt_clear_flags: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        take && i_op == CIS_OP_WDT_CLEAR |=> o_timeout_flag
        && o_powerdown_flag && o_watchdog_counter == 8'h00
        && o_watchdog_prescaler == 8'h00) // RQ1
        else $error("watchdog clear did not take effect");
    a_call_via_working_instr_push: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        take && i_op == CIS_OP_CALL_W |=> o_push
        && o_top_of_return_stack == $past(o_pc) + 15'h0001) // RQ2
        else $error("call did not push return address");
    a_call_via_working_instr_target: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        take && i_op == CIS_OP_CALL_W |=>
        o_pc == {$past(i_pc_high_latch), $past(o_working)}) // RQ3
        else $error("call target wrong");
    a_call_via_working_instr_two_cyc: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        take && i_op == CIS_OP_CALL_W |=> !o_ready ##1 o_ready
        and ##1 $stable(o_zero_flag)) // RQ4
        else $error("call not two cycles or flag changed");
    a_dest_routing: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        take && i_op == CIS_OP_DEC_F && i_dest == CIS_DEST_W
        |-> !o_fwe ##1 o_working == $past(i_fdata) - 8'h01) // RQ5 RQ7
        else $error("decrement to working register wrong");
    a_comp_zero: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        take && i_op == CIS_OP_COMP_F |=>
        o_zero_flag == ($past(i_fdata) == 8'hff)) // RQ6 RQ11
        else $error("complement zero flag wrong");
    a_clear_file: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        take && i_op == CIS_OP_CLEAR_F |-> o_fwe && o_fwdata == 8'h00
        ##1 o_zero_flag) // RQ8
        else $error("clear file wrong");
    a_clear_work: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        take && i_op == CIS_OP_CLEAR_W |=>
        o_working == 8'h00 && o_zero_flag) // RQ9
        else $error("clear working wrong");
    a_skip_nop: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        take && i_op == CIS_OP_DEC_SKIP |=> $stable(o_zero_flag)
        && (o_discard == ($past(i_fdata) == 8'h01))) // RQ10
        else $error("decrement skip wrong");

    // Result values and flag for the file-sourced ops
    a_dec_zero_flag: assert property (@(posedge i_ref_clk) // RQ7 RQ11
        disable iff (!i_resetn)
        take && i_op == CIS_OP_DEC_F |=>
        o_zero_flag == ($past(i_fdata) == 8'h01))
        else $error("decrement zero flag wrong");

    a_dec_file_data: assert property (@(posedge i_ref_clk) // RQ7
        disable iff (!i_resetn)
        take && i_op == CIS_OP_DEC_F && i_dest == CIS_DEST_F |->
        o_fwe && o_fwdata == i_fdata - 8'h01)
        else $error("decrement file data wrong");

    a_comp_file_data: assert property (@(posedge i_ref_clk) // RQ6
        disable iff (!i_resetn)
        take && i_op == CIS_OP_COMP_F && i_dest == CIS_DEST_F |->
        o_fwe && o_fwdata == ~i_fdata)
        else $error("complement file data wrong");

    a_comp_to_work: assert property (@(posedge i_ref_clk) // RQ5 RQ6
        disable iff (!i_resetn)
        take && i_op == CIS_OP_COMP_F && i_dest == CIS_DEST_W |->
        !o_fwe ##1 o_working == ~$past(i_fdata))
        else $error("complement to working register wrong");

    // A file destination must leave the working register alone
    a_dest_file_keep: assert property (@(posedge i_ref_clk) // RQ5
        disable iff (!i_resetn)
        take && i_dest == CIS_DEST_F && (i_op == CIS_OP_COMP_F
        || i_op == CIS_OP_DEC_F || i_op == CIS_OP_DEC_SKIP) |->
        o_fwe ##1 $stable(o_working))
        else $error("file destination touched working register");

    a_skip_result: assert property (@(posedge i_ref_clk) // RQ10
        disable iff (!i_resetn)
        take && i_op == CIS_OP_DEC_SKIP && i_dest == CIS_DEST_F |->
        o_fwdata == i_fdata - 8'h01)
        else $error("decrement skip data wrong");

    // The inserted no-op must neither write nor accept work
    a_flush_no_write: assert property (@(posedge i_ref_clk) // RQ10
        disable iff (!i_resetn)
        o_discard |-> !o_fwe && !o_ready)
        else $error("inserted no-op wrote or accepted");

    a_push_pulse: assert property (@(posedge i_ref_clk) // RQ2
        disable iff (!i_resetn)
        o_push |=> !o_push)
        else $error("push longer than one cycle");

    a_clear_w_nofile: assert property (@(posedge i_ref_clk) // RQ9
        disable iff (!i_resetn)
        take && i_op == CIS_OP_CLEAR_W |-> !o_fwe)
        else $error("clear working wrote file register");

    a_wdt_no_write: assert property (@(posedge i_ref_clk) // RQ1
        disable iff (!i_resetn)
        take && i_op == CIS_OP_WDT_CLEAR |-> !o_fwe
        ##1 $stable(o_working))
        else $error("watchdog clear touched data");

    // Straight-line ops step the program counter by one
    a_pc_step: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        take && i_op != CIS_OP_CALL_W |=>
        o_pc == $past(o_pc) + 15'h0001)
        else $error("program counter did not step");

    c_call_via_working_instr: cover property (@(posedge i_ref_clk)
        take && i_op == CIS_OP_CALL_W);
    c_comp_to_work: cover property (@(posedge i_ref_clk)
        take && i_op == CIS_OP_COMP_F && i_dest == CIS_DEST_W);
    c_skip_taken: cover property (@(posedge i_ref_clk)
        take && i_op == CIS_OP_DEC_SKIP && i_fdata == 8'h01);
    c_dec_to_file: cover property (@(posedge i_ref_clk)
        take && i_op == CIS_OP_DEC_F && i_dest == CIS_DEST_F);
    c_wdt_clear: cover property (@(posedge i_ref_clk)
        take && i_op == CIS_OP_WDT_CLEAR);

endmodule

`default_nettype wire

// file: core_instruction_subset_bench.sv
// Self-checking bench for the core instruction subset executor.
// Bench stands in for fetch unit and file array, driving at falling edge.
`timescale 1ns/100ps
`default_nettype none
module core_instruction_subset_bench
    import cis_pkg::*;
;
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_valid = 1'b0;
    cis_op_t i_op = CIS_OP_NOP;
    logic [6:0] i_faddr = 7'h00;
    logic i_dest = 1'b0;
    logic [7:0] i_fdata = 8'h00;
    logic [6:0] i_pc_high_latch = 7'h55;
    logic [6:0] o_faddr;
    logic o_fwe, o_push, o_ready, o_discard;
    logic o_zero_flag, o_timeout_flag, o_powerdown_flag;
    logic [7:0] o_fwdata, o_working, o_watchdog_counter, o_watchdog_prescaler;
    logic [14:0] o_pc, o_top_of_return_stack;
    int fails = 0;
    int comparisons = 0;
    logic [14:0] epc;
    logic fwe_s;
    logic [7:0] fwd_s;

    cis_core cis_core_i (.i_ref_clk, .i_resetn, .i_valid, .i_op, .i_faddr,
        .i_dest, .i_fdata, .o_faddr, .o_fwe, .o_fwdata, .i_pc_high_latch,
        .o_pc, .o_push, .o_top_of_return_stack, .o_ready, .o_discard,
        .o_working, .o_zero_flag, .o_timeout_flag, .o_powerdown_flag,
        .o_watchdog_counter, .o_watchdog_prescaler);

    // 20 MHz instruction clock
    always #25 i_ref_clk = ~i_ref_clk;

    task automatic cmp(input logic [14:0] got, input logic [14:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One accepted op; comb write captured before the taking edge
    task automatic issue(input cis_op_t op, input logic [6:0] fa,
                         input logic d, input logic [7:0] fd);
        @(negedge i_ref_clk);
        i_valid = 1'b1;
        i_op = op;
        i_faddr = fa;
        i_dest = d;
        i_fdata = fd;
        #1;
        cmp(o_ready, 1'b1);
        cmp(o_faddr, fa);
        fwe_s = o_fwe;
        fwd_s = o_fwdata;
        @(posedge i_ref_clk);
        #1;
        epc = epc + 15'h0001;
        // Call target is judged by its own scenario
        if (op != CIS_OP_CALL_W) begin
            cmp(o_pc, epc);
        end
    endtask

    // Inserted no-op; a clear is offered to prove it is ignored
    task automatic flush();
        @(negedge i_ref_clk);
        i_op = CIS_OP_CLEAR_W;
        #1;
        cmp(o_ready, 1'b0);
        cmp(o_discard, 1'b1);
        @(posedge i_ref_clk);
        #1;
        epc = epc + 15'h0001;
        cmp(o_pc, epc);
    endtask

    task automatic t_reset();
        cmp(o_pc, CIS_PC_RST);
        cmp(o_working, CIS_W_RST);
        cmp(o_zero_flag, 1'b0);
        cmp({o_timeout_flag, o_powerdown_flag}, 2'h3);
        cmp(o_push, 1'b0);
        cmp(o_discard, 1'b0);
    endtask

    task automatic t_decrement();
        issue(CIS_OP_DEC_F, 7'h11, CIS_DEST_W, 8'h01);
        cmp(fwe_s, 1'b0);
        cmp(o_working, 8'h00);
        cmp(o_zero_flag, 1'b1);
        issue(CIS_OP_DEC_F, 7'h12, CIS_DEST_F, 8'h00);
        cmp(fwe_s, 1'b1);
        cmp(fwd_s, 8'hff);
        cmp(o_zero_flag, 1'b0);
        cmp(o_working, 8'h00);
    endtask

    task automatic t_comp_clear();
        issue(CIS_OP_COMP_F, 7'h00, CIS_DEST_F, 8'hff);
        cmp(fwd_s, 8'h00);
        cmp(o_zero_flag, 1'b1);
        issue(CIS_OP_COMP_F, 7'h20, CIS_DEST_W, 8'h5a);
        cmp(o_working, 8'ha5);
        cmp(o_zero_flag, 1'b0);
        issue(CIS_OP_CLEAR_W, 7'h21, CIS_DEST_F, 8'h77);
        cmp(o_working, 8'h00);
        cmp(o_zero_flag, 1'b1);
        issue(CIS_OP_DEC_F, 7'h22, CIS_DEST_W, 8'h05);
        issue(CIS_OP_CLEAR_F, 7'h7f, CIS_DEST_W, 8'h33);
        cmp({fwe_s, fwd_s}, 9'h100);
        cmp(o_zero_flag, 1'b1);
        cmp(o_working, 8'h04);
    endtask

    task automatic t_call();
        issue(CIS_OP_COMP_F, 7'h30, CIS_DEST_W, 8'hcb);
        issue(CIS_OP_CALL_W, 7'h31, CIS_DEST_F, 8'h00);
        cmp(o_push, 1'b1);
        cmp(o_top_of_return_stack, epc);
        epc = {i_pc_high_latch, 8'h34};
        cmp(o_pc, epc);
        cmp(o_zero_flag, 1'b0);
        flush();
        cmp(o_push, 1'b0);
        cmp(o_working, 8'h34);
    endtask

    task automatic t_skip_wdt();
        issue(CIS_OP_DEC_SKIP, 7'h05, CIS_DEST_F, 8'h01);
        cmp({fwe_s, fwd_s}, 9'h100);
        cmp(o_zero_flag, 1'b0);
        flush();
        cmp(o_working, 8'h34);
        issue(CIS_OP_CLEAR_W, 7'h06, CIS_DEST_W, 8'h00);
        issue(CIS_OP_DEC_SKIP, 7'h07, CIS_DEST_W, 8'h02);
        cmp(o_working, 8'h01);
        cmp(o_zero_flag, 1'b1);
        issue(CIS_OP_WDT_CLEAR, 7'h08, CIS_DEST_F, 8'h00);
        cmp(o_watchdog_counter, CIS_WDT_CLR);
        cmp(o_watchdog_prescaler, CIS_PRE_CLR);
        cmp({o_timeout_flag, o_powerdown_flag}, 2'h3);
        cmp(o_working, 8'h01);
    endtask

    // Watchdog: tests need well under a hundred cycles
    initial begin
        repeat (400) @(posedge i_ref_clk);
        fails++;
        summarize();
    end

    // Reset held six cycles, released off the taking edge
    initial begin
        repeat (6) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        t_reset();
        i_resetn = 1'b1;
        epc = CIS_PC_RST;
        t_decrement();
        t_comp_clear();
        t_call();
        t_skip_wdt();
        summarize();
    end
endmodule
`default_nettype wire
